// file: iop_pkg.sv
// Constants, reset values and helpers for the I/O pad reset and low-power control block
package iop_pkg;

  localparam int IOP_NPINS = 26;
  localparam int IOP_AW = 12;

  // Register byte offsets
  localparam logic [11:0] IOP_OFF_DATA = 12'h000;
  localparam logic [11:0] IOP_OFF_DIR = 12'h004;
  localparam logic [11:0] IOP_OFF_PULL = 12'h008;
  localparam logic [11:0] IOP_OFF_DRIVE = 12'h00c;
  localparam logic [11:0] IOP_OFF_MODE0 = 12'h02c;
  localparam logic [11:0] IOP_OFF_MODE_SEL_PINS_8_15 = 12'h030;
  localparam logic [11:0] IOP_OFF_MODE2 = 12'h034;
  localparam logic [11:0] IOP_OFF_MODE3 = 12'h038;
  localparam logic [11:0] IOP_OFF_DSET = 12'h03c;
  localparam logic [11:0] IOP_OFF_DCLR = 12'h040;
  localparam logic [11:0] IOP_OFF_LPCFG = 12'h048;
  localparam logic [11:0] IOP_OFF_STATUS = 12'h04c;

  // Reset values
  localparam logic [25:0] IOP_RST_PULL = 26'h3ffffff;
  localparam logic [31:0] IOP_RST_MODE_SEL_PINS_8_15 = 32'h00000110;
  localparam logic [31:0] IOP_RST_MODE = 32'h00000000;
  localparam logic [25:0] IOP_RST_PINS = 26'h0000000;
  localparam logic [8:0] IOP_RST_LPCFG = 9'h000;

  // Field layout of the low-power configuration of pins 9..11
  localparam int IOP_LP_OE_LSB = 0;
  localparam int IOP_LP_OUT_LSB = 3;
  localparam int IOP_LP_PULL_LSB = 6;
  localparam int IOP_LP_FIRST_PIN = 9;
  localparam int IOP_STAT_LP_BIT = 0;
  localparam int IOP_STAT_PULSE_BIT = 1;

  // Mode field layout: 4 bits per pin, 3 used, 8 pins per word
  localparam int IOP_MODE_FW = 4;
  localparam int IOP_MODE_PER_WORD = 8;
  localparam logic [2:0] IOP_MODE_GPIO = 3'h0;

  // Pin classes
  localparam logic [25:0] IOP_PULLUP_MASK = 26'h0000e00;
  localparam logic [25:0] IOP_NOPULL_MASK = 26'h0003000;
  localparam logic [25:0] IOP_LPCFG_MASK = 26'h0000e00;
  localparam int IOP_PULSE_PIN = 14;

  // Reset pulse on the shared analog test line
  localparam int IOP_PULSE_US = 75;
  localparam int IOP_CLK_MHZ = 100;
  localparam int IOP_PULSE_CYCLES = IOP_PULSE_US * IOP_CLK_MHZ;
  localparam int IOP_CNT_W = 16;
  localparam logic [1:0] IOP_SYNC_SETTLE = 2'h2;

  // Mode of one pin out of the four mode words
  function automatic logic [2:0] iop_mode_of(input logic [31:0] m0, input logic [31:0] m1,
                                             input logic [31:0] m2, input logic [31:0] m3, input int pin);
    logic [31:0] w;
    int f;
    w = m0;
    f = (pin % IOP_MODE_PER_WORD) * IOP_MODE_FW;
    unique case (pin / IOP_MODE_PER_WORD)
      0: w = m0;
      1: w = m1;
      2: w = m2;
      default: w = m3;
    endcase
    return w[f +: 3];
  endfunction

endpackage

// file: iop_cfg_if.sv
// Interface carrying pad configuration from the register side to the pad drivers
`timescale 1ns/1ps
interface iop_cfg_if;
  logic [25:0] dout; // Run-mode output levels
  logic [25:0] dir; // Run-mode output enables
  logic [25:0] pull; // Run-mode pull enables
  logic [31:0] mode0; // Modes pins 0-7
  logic [31:0] mode_sel_pins_8_15; // Modes pins 8-15
  logic [31:0] mode2; // Modes pins 16-23
  logic [31:0] mode3; // Modes pins 24-25
  logic [8:0] lpcfg; // Low-power setup of pins 9-11
  logic lp_mode; // Sleep or standby active
  logic tst_pulse; // Reset pulse on pin 14 active

  modport regs (output dout, dir, pull, mode0, mode_sel_pins_8_15, mode2, mode3, lpcfg, lp_mode, tst_pulse);
  modport pads (input dout, dir, pull, mode0, mode_sel_pins_8_15, mode2, mode3, lpcfg, lp_mode, tst_pulse);
endinterface

// file: iop_pad_drv.sv
// Registered pad driver: run mode, low-power override and reset pulse
`timescale 1ns/1ps
module iop_pad_drv
  import iop_pkg::*;
(
  input wire logic sys_clk, // System clock
  input wire logic resetn, // Async reset, active low
  iop_cfg_if.pads cfg, // Configuration from registers
  input wire logic [25:0] alt_out, // Peripheral output levels
  input wire logic [25:0] alt_oe, // Peripheral output enables
  output logic [25:0] pad_out, // Pad output level
  output logic [25:0] pad_oe, // Pad driver enable
  output logic [25:0] pad_pu, // Pull-up enable
  output logic [25:0] pad_pd // Pull-down enable
);

  logic [25:0] out_d, oe_d, pu_d, pd_d;
  logic [25:0] out_q, oe_q, pu_q, pd_q;

  // Per-pin selection; settings come straight from the registers, so leaving
  // low power restores the run-mode state with no extra bookkeeping
  always_comb begin
    logic gpio;
    logic pen;
    int k;
    gpio = 1'b0;
    pen = 1'b0;
    k = 0;
    for (int i = 0; i < IOP_NPINS; i++) begin
      gpio = (iop_mode_of(cfg.mode0, cfg.mode_sel_pins_8_15, cfg.mode2, cfg.mode3, i) == IOP_MODE_GPIO);
      pen = cfg.pull[i] & ~IOP_NOPULL_MASK[i];
      out_d[i] = gpio ? cfg.dout[i] : alt_out[i];
      oe_d[i] = gpio ? (cfg.dir[i] & ~IOP_NOPULL_MASK[i]) : alt_oe[i];
      pu_d[i] = pen & IOP_PULLUP_MASK[i];
      pd_d[i] = pen & ~IOP_PULLUP_MASK[i];
      if (cfg.lp_mode) begin
        if (IOP_LPCFG_MASK[i]) begin
          k = i - IOP_LP_FIRST_PIN;
          oe_d[i] = cfg.lpcfg[IOP_LP_OE_LSB + k];
          out_d[i] = cfg.lpcfg[IOP_LP_OUT_LSB + k];
          pu_d[i] = cfg.lpcfg[IOP_LP_PULL_LSB + k];
          pd_d[i] = 1'b0;
        end else begin
          // Pins 12, 13 stay unpulled inputs; all others float except pin 14 while the reset pulse runs
          oe_d[i] = 1'b0;
          out_d[i] = 1'b0;
          pu_d[i] = 1'b0;
          pd_d[i] = 1'b0;
        end
      end
      if (cfg.tst_pulse && i == IOP_PULSE_PIN) begin
        oe_d[i] = 1'b1;
        out_d[i] = 1'b1;
      end
    end
  end

  // Pad flops clear under reset so no driver or pull is on
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      out_q <= IOP_RST_PINS;
      oe_q <= IOP_RST_PINS;
      pu_q <= IOP_RST_PINS;
      pd_q <= IOP_RST_PINS;
    end else begin
      out_q <= out_d;
      oe_q <= oe_d;
      pu_q <= pu_d;
      pd_q <= pd_d;
    end
  end

  assign pad_out = out_q;
  assign pad_oe = oe_q;
  assign pad_pu = pu_q;
  assign pad_pd = pd_q;

endmodule // iop_pad_drv

// file: iop_io_pad_ctrl.sv
// Top of the I/O pad reset and low-power control block with its APB register file
`timescale 1ns/1ps
module iop_io_pad_ctrl
  import iop_pkg::*;
#(
  parameter int PULSE_CYCLES = IOP_PULSE_CYCLES // Length of the pin 14 reset pulse
) (
  input wire logic sys_clk, // System clock, 100 MHz
  input wire logic resetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic sleep_mode, // Sleep request from power control
  input wire logic standby_mode, // Standby request from power control
  input wire logic small_pkg, // Package strap, high on small packages
  input wire logic [25:0] pad_in, // Pad input levels
  input wire logic [25:0] alt_out, // Peripheral output levels
  input wire logic [25:0] alt_oe, // Peripheral output enables
  output logic [25:0] pad_out, // Pad output level
  output logic [25:0] pad_oe, // Pad driver enable
  output logic [25:0] pad_pu, // Pull-up enable
  output logic [25:0] pad_pd, // Pull-down enable
  output logic [25:0] pad_ds, // High drive select
  output logic analog_test_line // Reset pulse on shared test line
);

  typedef enum logic [1:0] {IOP_ST_SETTLE, IOP_ST_PULSE, IOP_ST_DONE} iop_pulse_e;

  localparam logic [IOP_CNT_W-1:0] PULSE_LAST = IOP_CNT_W'(PULSE_CYCLES - 1);

  iop_cfg_if cfg ();

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  logic [25:0] pin_s1_q, pin_s2_q;
  logic strap_s1_q, strap_s2_q;

  // Pads and strap are asynchronous; first stage feeds only the second
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pin_s1_q <= IOP_RST_PINS;
      pin_s2_q <= IOP_RST_PINS;
      strap_s1_q <= 1'b0;
      strap_s2_q <= 1'b0;
    end else begin
      pin_s1_q <= pad_in;
      pin_s2_q <= pin_s1_q;
      strap_s1_q <= small_pkg;
      strap_s2_q <= strap_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset pulse sequencer for pin 14

  iop_pulse_e pst_q, pst_d;
  logic [IOP_CNT_W-1:0] pcnt_q, pcnt_d;
  logic atl_q, atl_d;

  // Strap is judged only once the synchroniser has filled after release
  always_comb begin
    pst_d = pst_q;
    pcnt_d = pcnt_q;
    atl_d = 1'b0;
    unique case (pst_q)
      IOP_ST_SETTLE: begin
        pcnt_d = pcnt_q + 1'b1;
        if (pcnt_q[1:0] == IOP_SYNC_SETTLE) begin
          pcnt_d = '0;
          pst_d = strap_s2_q ? IOP_ST_PULSE : IOP_ST_DONE;
          atl_d = strap_s2_q;
        end
      end
      IOP_ST_PULSE: begin
        atl_d = 1'b1;
        pcnt_d = pcnt_q + 1'b1;
        if (pcnt_q == PULSE_LAST) begin
          atl_d = 1'b0;
          pst_d = IOP_ST_DONE;
          pcnt_d = '0;
        end
      end
      IOP_ST_DONE: begin
        pcnt_d = '0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pst_q <= IOP_ST_SETTLE;
      pcnt_q <= '0;
      atl_q <= 1'b0;
    end else begin
      pst_q <= pst_d;
      pcnt_q <= pcnt_d;
      atl_q <= atl_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB register file

  logic [25:0] dout_q, dout_d;
  logic [25:0] dir_q, dir_d;
  logic [25:0] pull_q, pull_d;
  logic [25:0] ds_q, ds_d;
  logic [31:0] mode0_q, mode0_d, mode_sel_pins_8_15_q, mode_sel_pins_8_15_d, mode2_q, mode2_d, mode3_q, mode3_d;
  logic [8:0] lpcfg_q, lpcfg_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic lp_mode;

  assign lp_mode = sleep_mode | standby_mode;

  // Address decode shared by read and write paths
  function automatic logic iop_mapped(input logic [11:0] a);
    return a == IOP_OFF_DATA || a == IOP_OFF_DIR || a == IOP_OFF_PULL || a == IOP_OFF_DRIVE ||
           a == IOP_OFF_MODE0 || a == IOP_OFF_MODE_SEL_PINS_8_15 || a == IOP_OFF_MODE2 || a == IOP_OFF_MODE3 ||
           a == IOP_OFF_DSET || a == IOP_OFF_DCLR || a == IOP_OFF_LPCFG || a == IOP_OFF_STATUS;
  endfunction

  // Answer is prepared in setup, so every access phase lasts one cycle
  always_comb begin
    logic wr;
    wr = psel & penable & pready_q & pwrite & ~pslverr_q;
    dout_d = dout_q;
    dir_d = dir_q;
    pull_d = pull_q;
    ds_d = ds_q;
    mode0_d = mode0_q;
    mode_sel_pins_8_15_d = mode_sel_pins_8_15_q;
    mode2_d = mode2_q;
    mode3_d = mode3_q;
    lpcfg_d = lpcfg_q;
    pready_d = psel & ~penable;
    pslverr_d = psel & ~penable & ~iop_mapped(paddr);
    prdata_d = '0;
    if (psel && !penable && !pwrite) begin
      unique case (paddr)
        IOP_OFF_DATA: prdata_d = {6'h00, pin_s2_q};
        IOP_OFF_DIR: prdata_d = {6'h00, dir_q};
        IOP_OFF_PULL: prdata_d = {6'h00, pull_q};
        IOP_OFF_DRIVE: prdata_d = {6'h00, ds_q};
        IOP_OFF_MODE0: prdata_d = mode0_q;
        IOP_OFF_MODE_SEL_PINS_8_15: prdata_d = mode_sel_pins_8_15_q;
        IOP_OFF_MODE2: prdata_d = mode2_q;
        IOP_OFF_MODE3: prdata_d = mode3_q;
        IOP_OFF_DSET: prdata_d = {6'h00, dout_q};
        IOP_OFF_DCLR: prdata_d = {6'h00, dout_q};
        IOP_OFF_LPCFG: prdata_d = {23'h000000, lpcfg_q};
        IOP_OFF_STATUS: begin
          prdata_d[IOP_STAT_LP_BIT] = lp_mode;
          prdata_d[IOP_STAT_PULSE_BIT] = atl_q;
        end
        default: prdata_d = '0;
      endcase
    end
    if (wr) begin
      unique case (paddr)
        IOP_OFF_DATA: dout_d = pwdata[25:0];
        IOP_OFF_DIR: dir_d = pwdata[25:0];
        IOP_OFF_PULL: pull_d = pwdata[25:0];
        IOP_OFF_DRIVE: ds_d = pwdata[25:0];
        IOP_OFF_MODE0: mode0_d = pwdata;
        IOP_OFF_MODE_SEL_PINS_8_15: mode_sel_pins_8_15_d = pwdata;
        IOP_OFF_MODE2: mode2_d = pwdata;
        IOP_OFF_MODE3: mode3_d = pwdata;
        IOP_OFF_DSET: dout_d = dout_q | pwdata[25:0];
        IOP_OFF_DCLR: dout_d = dout_q & ~pwdata[25:0];
        IOP_OFF_LPCFG: lpcfg_d = pwdata[8:0];
        default: dout_d = dout_q;
      endcase
    end
  end

  // Register state; pin defaults come from these reset values
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      dout_q <= IOP_RST_PINS;
      dir_q <= IOP_RST_PINS;
      pull_q <= IOP_RST_PULL;
      ds_q <= IOP_RST_PINS;
      mode0_q <= IOP_RST_MODE;
      mode_sel_pins_8_15_q <= IOP_RST_MODE_SEL_PINS_8_15;
      mode2_q <= IOP_RST_MODE;
      mode3_q <= IOP_RST_MODE;
      lpcfg_q <= IOP_RST_LPCFG;
      prdata_q <= '0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      dout_q <= dout_d;
      dir_q <= dir_d;
      pull_q <= pull_d;
      ds_q <= ds_d;
      mode0_q <= mode0_d;
      mode_sel_pins_8_15_q <= mode_sel_pins_8_15_d;
      mode2_q <= mode2_d;
      mode3_q <= mode3_d;
      lpcfg_q <= lpcfg_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pad drivers

  // Low-power override reads the live request; the run settings stay
  // untouched in the registers and reappear on exit
  assign cfg.dout = dout_q;
  assign cfg.dir = dir_q;
  assign cfg.pull = pull_q;
  assign cfg.mode0 = mode0_q;
  assign cfg.mode_sel_pins_8_15 = mode_sel_pins_8_15_q;
  assign cfg.mode2 = mode2_q;
  assign cfg.mode3 = mode3_q;
  assign cfg.lpcfg = lpcfg_q;
  assign cfg.lp_mode = lp_mode;
  assign cfg.tst_pulse = atl_q;

  iop_pad_drv u_pad (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .cfg(cfg),
    .alt_out(alt_out),
    .alt_oe(alt_oe),
    .pad_out(pad_out),
    .pad_oe(pad_oe),
    .pad_pu(pad_pu),
    .pad_pd(pad_pd)
  );

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign pad_ds = ds_q;
  assign analog_test_line = atl_q;

endmodule // iop_io_pad_ctrl

// file: iop_pad_board.sv
// Behavioural model of the pads and board around the I/O pad control block
`timescale 1ns/1ps
module iop_pad_board (
  input wire logic sys_clk, // Clock for the floating-pin pattern
  input wire logic [25:0] pad_out, // Level driven by the block
  input wire logic [25:0] pad_oe, // Driver enables
  input wire logic [25:0] pad_pu, // Pull-up enables
  input wire logic [25:0] pad_pd, // Pull-down enables
  output logic [25:0] pad_in // Resolved pad levels
);
  ////////////////////////////////////////
  // Board pull-downs keep pins 12 and 13 at a defined level
  localparam logic [25:0] BOARD_PD = 26'h0003000;
  logic [25:0] float_q = 26'h2aaaaaa;

  // A floating pin never shows its last value, so it toggles every cycle
  always @(posedge sys_clk) float_q <= ~float_q;

  // Driver wins, then internal pulls, then board pulls, else floating
  always_comb begin
    for (int i = 0; i < 26; i++) begin
      if (pad_oe[i]) pad_in[i] = pad_out[i];
      else if (pad_pu[i]) pad_in[i] = 1'b1;
      else if (pad_pd[i] || BOARD_PD[i]) pad_in[i] = 1'b0;
      else pad_in[i] = float_q[i];
    end
  end
endmodule // iop_pad_board

// file: iop_io_pad_ctrl_sva.sv
// Concurrent checks on the ports of the I/O pad control block
`timescale 1ns/1ps
module iop_io_pad_ctrl_sva #(
  parameter int PULSE_CYCLES = 7500 // Length of the pin 14 reset pulse
) (
  input wire logic sys_clk, // System clock
  input wire logic resetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic sleep_mode, // Sleep request
  input wire logic standby_mode, // Standby request
  input wire logic small_pkg, // Package strap
  input wire logic [25:0] pad_out, // Pad output level
  input wire logic [25:0] pad_oe, // Pad driver enable
  input wire logic [25:0] pad_pu, // Pull-up enable
  input wire logic [25:0] pad_pd, // Pull-down enable
  input wire logic analog_test_line // Test line pulse
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  ////////////////////////////////////////
  // Edges since reset release and length of the current pulse
  logic [1:0] rel_q, rel_d;
  logic [15:0] run_q, run_d;
  wire lp = sleep_mode | standby_mode;

  // Release counter saturates; only the first edges matter
  always_comb begin
    rel_d = (rel_q == 2'h3) ? rel_q : rel_q + 2'h1;
    run_d = analog_test_line ? run_q + 16'h0001 : 16'h0000;
  end

  // Helper registers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rel_q <= 2'h0;
      run_q <= 16'h0000;
    end else begin
      rel_q <= rel_d;
      run_q <= run_d;
    end
  end

  ////////////////////////////////////////
  // Assertions
  reset_undriven_a: assert property (disable iff (1'b0) !resetn |-> (pad_oe | pad_pu | pad_pd) == 26'h0)
    else $error("pad driven or pulled during reset");
  reset_pulls_a: assert property (rel_q == 2'h1 && !$past(lp) |-> pad_pd == 26'h3ffc1ff && pad_pu == 26'h0000e00)
    else $error("wrong pulls after reset");
  lp_hiz_a: assert property (lp [*2] |=> ((pad_oe | pad_pu | pad_pd) & 26'h3ffc1ff) == 26'h0 || $past(analog_test_line))
    else $error("pin not high impedance in low power");
  lp_fixed_input_a: assert property (lp [*2] |=> (pad_oe[13:12] | pad_pu[13:12] | pad_pd[13:12]) == 2'b00)
    else $error("pin 12 or 13 not unpulled input in low power");
  pulse_len_a: assert property ($fell(analog_test_line) |-> run_q == PULSE_CYCLES)
    else $error("test line pulse length wrong");
  pulse_pad_a: assert property (analog_test_line |=> pad_oe[14] && pad_out[14])
    else $error("pin 14 does not follow test line pulse");
  pulse_strap_a: assert property ($rose(analog_test_line) |-> small_pkg && rel_q == 2'h3)
    else $error("test line pulse without small package");
  apb_ready_a: assert property (psel && !penable |=> pready)
    else $error("no ready in access phase");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  slverr_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
endmodule // iop_io_pad_ctrl_sva

// file: iop_io_pad_ctrl_tb.sv
// Self-checking testbench for the I/O pad reset and low-power control block
`timescale 1ns/1ps
module iop_io_pad_ctrl_tb;
  import iop_pkg::*;
  localparam int PULSE = 20;
  logic sys_clk, resetn, psel, penable, pwrite, sleep_mode, standby_mode, small_pkg, pready, pslverr, analog_test_line;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_q;
  logic err_q;
  logic [25:0] pad_in, alt_out, alt_oe, pad_out, pad_oe, pad_pu, pad_pd, pad_ds;
  int n_errors = 0;
  int checked = 0;

  ////////////////////////////////////////
  // Clock at 100 MHz
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Short pulse parameter keeps the run brief
  iop_io_pad_ctrl #(.PULSE_CYCLES(PULSE)) dut (.sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleep_mode(sleep_mode), .standby_mode(standby_mode), .small_pkg(small_pkg), .pad_in(pad_in),
    .alt_out(alt_out), .alt_oe(alt_oe), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pu(pad_pu), .pad_pd(pad_pd),
    .pad_ds(pad_ds), .analog_test_line(analog_test_line));
  iop_pad_board board (.sys_clk(sys_clk), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pu(pad_pu), .pad_pd(pad_pd),
    .pad_in(pad_in));

  ////////////////////////////////////////
  // Compare and close
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done;
    $display("checked=%0d n_errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // One APB transfer; request held until pready is sampled at a rising edge, then one idle cycle
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Flop outputs still hold their pre-edge values here, as the slave saw them
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic experr);
    apb(1'b0, a, 32'h0);
    cmp(rd_q, exp);
    cmp({31'h0, err_q}, {31'h0, experr});
  endtask

  // Reset with a given strap, then check defaults and the test-line pulse
  task automatic do_reset(input logic pkg);
    int n;
    n = 0;
    resetn <= 1'b0;
    small_pkg <= pkg;
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
    cmp(pad_oe | pad_pu | pad_pd, 32'h0);
    @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (2) @(negedge sys_clk);
    cmp(pad_pd, 32'h03ffc1ff);
    cmp(pad_pu, 32'h00000e00);
    cmp(pad_oe, 32'h0);
    repeat (40) begin
      @(negedge sys_clk);
      n += int'(analog_test_line === 1'b1);
    end
    cmp(n, pkg ? PULSE : 0);
    $display("test reset pkg=%0d done", pkg);
    @(posedge sys_clk);
  endtask

  ////////////////////////////////////////
  // Main sequence
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    sleep_mode = 1'b0;
    standby_mode = 1'b0;
    alt_out = 26'h0000000;
    alt_oe = 26'h0000000;
    do_reset(1'b1);
    rd(IOP_OFF_PULL, 32'h03ffffff, 1'b0);
    rd(IOP_OFF_MODE_SEL_PINS_8_15, 32'h00000110, 1'b0);
    rd(IOP_OFF_DATA, 32'h00000e00, 1'b0);
    rd(IOP_OFF_MODE0, 32'h00000000, 1'b0);
    rd(IOP_OFF_MODE3, 32'h00000000, 1'b0);
    rd(12'h050, 32'h0, 1'b1);
    $display("test register defaults done");
    // All pins set to output; 12 and 13 must stay undriven, 9 and 10 follow their peripheral
    alt_oe <= 26'h0000600;
    alt_out <= 26'h0000200;
    apb(1'b1, IOP_OFF_DIR, 32'h03ffffff);
    apb(1'b1, IOP_OFF_DATA, 32'h000000a5);
    repeat (4) @(negedge sys_clk);
    cmp(pad_oe, 32'h03ffcfff);
    rd(IOP_OFF_DATA, 32'h000002a5, 1'b0);
    // Set then clear single output bits without touching the others
    apb(1'b1, IOP_OFF_DSET, 32'h00000100);
    apb(1'b1, IOP_OFF_DCLR, 32'h00000005);
    rd(IOP_OFF_DSET, 32'h000001a0, 1'b0);
    $display("test output drive done");
    // Sleep, then standby: pins 9 and 11 driven, 10 pulled up, rest released
    apb(1'b1, IOP_OFF_LPCFG, 32'h0000008d);
    for (int m = 1; m <= 2; m++) begin
      {standby_mode, sleep_mode} <= m[1:0];
      repeat (3) @(negedge sys_clk);
      cmp(pad_oe, 32'h00000a00);
      cmp(pad_out & 26'h0000e00, 32'h00000200);
      cmp(pad_pu, 32'h00000400);
      cmp(pad_pd, 32'h0);
      @(posedge sys_clk);
      rd(IOP_OFF_STATUS, 32'h00000001, 1'b0);
    end
    {standby_mode, sleep_mode} <= 2'b00;
    repeat (3) @(negedge sys_clk);
    cmp(pad_oe, 32'h03ffcfff);
    cmp(pad_pd, 32'h03ffc1ff);
    cmp(pad_pu, 32'h00000e00);
    $display("test low power done");
    // Clearing pin 0 pull must drop its pull-down; drive bits reach the pads
    @(posedge sys_clk);
    apb(1'b1, IOP_OFF_PULL, 32'h03fffffe);
    apb(1'b1, IOP_OFF_DRIVE, 32'h02a5a5a5);
    rd(IOP_OFF_DRIVE, 32'h02a5a5a5, 1'b0);
    @(negedge sys_clk);
    cmp(pad_pd, 32'h03ffc1fe);
    cmp(pad_ds, 32'h02a5a5a5);
    $display("test pull and drive done");
    @(posedge sys_clk);
    alt_oe <= 26'h0000000;
    do_reset(1'b0);
    test_done();
  end

  // Watchdog well beyond the expected run of under two hundred cycles
  initial begin
    repeat (3000) @(posedge sys_clk);
    n_errors++;
    test_done();
  end
endmodule // iop_io_pad_ctrl_tb

bind iop_io_pad_ctrl iop_io_pad_ctrl_sva #(.PULSE_CYCLES(PULSE_CYCLES)) u_sva (.sys_clk(sys_clk), .resetn(resetn),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .sleep_mode(sleep_mode),
  .standby_mode(standby_mode), .small_pkg(small_pkg), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pu(pad_pu),
  .pad_pd(pad_pd), .analog_test_line(analog_test_line));
